// File: design/cms_defines.svh
// Offsets, field positions, reset values and codes of the mode/status control block.
// Included by the encoder, the control top and the bench; definitions only.
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH

`define CMS_OFF_CONTROL 4'h0
`define CMS_OFF_STATUS 4'h4
`define CMS_OFF_FUNC 4'h8
`define CMS_OFF_FIFO 4'hC
`define CMS_REQ_CONFIG 3'h4
`define CMS_REQ_LISTEN 3'h3
`define CMS_REQ_LOOP 3'h2
`define CMS_REQ_SLEEP 3'h1
`define CMS_REQ_NORMAL 3'h0
`define CMS_CTL_REQ_LSB 5
`define CMS_CTL_ABORT_BIT 4
`define CMS_CTL_WIN_LSB 1
`define CMS_FMODE_LEGACY 2'h0
`define CMS_FMODE_ENH 2'h1
`define CMS_FMODE_FIFO 2'h2
`define CMS_IC_NONE 5'h00
`define CMS_IC_ERR 5'h02
`define CMS_IC_TX2 5'h04
`define CMS_IC_TX1 5'h06
`define CMS_IC_TX0 5'h08
`define CMS_IC_RX1_M0 5'h0A
`define CMS_IC_RX0_M0 5'h0C
`define CMS_IC_WAKE_M0 5'h0E
`define CMS_IC_WAKE_EN 5'h0E
`define CMS_IC_RX0_EN 5'h10
`define CMS_IC_RX1_EN 5'h11
`define CMS_IC_PROG0_EN 5'h12
`define CMS_WIN_RX0 3'h0
`define CMS_WIN_RX1 3'h5
`define CMS_WIN_TX0 3'h4
`define CMS_WIN_TX1 3'h3
`define CMS_WIN_TX2 3'h2
`define CMS_FP_LAST 4'h7
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2

`endif

// File: design/cms_pkg.sv
// Types shared by the mode/status control block.
// Assumes cms_defines.svh for numeric values.
package cms_pkg;
  typedef enum logic [2:0] {
    CMS_OP_NORMAL = 3'h0,
    CMS_OP_SLEEP = 3'h1,
    CMS_OP_LOOP = 3'h2,
    CMS_OP_LISTEN = 3'h3,
    CMS_OP_CONFIG = 3'h4
  } cms_mode_status_e;
  typedef logic [4:0] cms_irq_source_code_t;
endpackage

// File: design/cms_evt_if.sv
// Interrupt event bundle between the control top and the code encoder.
// Assumes one clock domain.
`timescale 1ns/1ps
interface cms_evt_if;
  logic err;
  logic wake;
  logic [2:0] tx;
  logic [1:0] rx;
  logic [5:0] prog;
  logic [5:0] prog_is_rx;
  logic [1:0] fmode;
  logic [4:0] code;
  modport src (output err, wake, tx, rx, prog, prog_is_rx, fmode, input code);
  modport enc (input err, wake, tx, rx, prog, prog_is_rx, fmode, output code);
endinterface

// File: design/cms_irq_encoder.sv
// Prioritized interrupt source encoder, combinational.
// Assumes event levels held by the protocol engine until serviced.
`timescale 1ns/1ps
`include "cms_defines.svh"
module cms_irq_encoder (
  cms_evt_if.enc ev
);
  always_comb begin
    ev.code = `CMS_IC_NONE;
    if (ev.fmode == `CMS_FMODE_LEGACY) begin
      // Codes of TX0-TX2 and RX1 match the window encoding so software can copy them over; the RX0 code gives 110, not window 000
      if (ev.err) ev.code = `CMS_IC_ERR;
      else if (ev.tx[2]) ev.code = `CMS_IC_TX2;
      else if (ev.tx[1]) ev.code = `CMS_IC_TX1;
      else if (ev.tx[0]) ev.code = `CMS_IC_TX0;
      else if (ev.rx[1]) ev.code = `CMS_IC_RX1_M0;
      else if (ev.rx[0]) ev.code = `CMS_IC_RX0_M0;
      else if (ev.wake) ev.code = `CMS_IC_WAKE_M0;
    end else begin
      if (ev.err) ev.code = `CMS_IC_ERR;
      else if (ev.tx[2]) ev.code = `CMS_IC_TX2;
      else if (ev.tx[1]) ev.code = `CMS_IC_TX1;
      else if (ev.tx[0]) ev.code = `CMS_IC_TX0;
      else if (ev.wake) ev.code = `CMS_IC_WAKE_EN;
      else if (ev.rx[0]) ev.code = `CMS_IC_RX0_EN;
      else if (ev.rx[1]) ev.code = `CMS_IC_RX1_EN;
      else begin
        for (int i = 5; i >= 0; i--) begin
          if (ev.prog[i]) begin
            // Receiving programmable buffers report the shared receive code
            ev.code = ev.prog_is_rx[i] ? `CMS_IC_RX0_EN : (`CMS_IC_PROG0_EN + 5'(i));
          end
        end
      end
    end
  end
endmodule

// File: design/cms_ctrl.sv
// Mode request / status, abort-all and window/interrupt-code control with AXI4-Lite regs.
// Assumes a protocol engine that reports bus idle and abort completion synchronously.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cms_defines.svh"
module cms_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine status
  input wire logic bus_idle,
  input wire logic tx_abort_done,
  input wire logic [3:0] fifo_read_pointer,
  input wire logic evt_err,
  input wire logic evt_wake,
  input wire logic [2:0] evt_tx,
  input wire logic [1:0] evt_rx,
  input wire logic [5:0] evt_prog,
  input wire logic [5:0] evt_prog_is_rx,
  // Protocol engine control
  output logic [2:0] mode_status_ff,
  output logic abort_all_tx_ff,
  output logic [2:0] buffer_window_select_ff,
  output logic [1:0] functional_mode_select_ff
);
  logic [2:0] mode_request_ff;
  cms_pkg::cms_irq_source_code_t irq_code_ff;
  logic [3:0] aw_addr_ff;
  logic aw_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_full_ff;
  logic [7:0] ctl_read;
  logic [7:0] stat_read;
  logic wr_fire;
  logic ctl_wr;
  logic fmode_wr;
  logic [2:0] nxt_mode_status;
  logic [2:0] wr_req_field;
  logic [2:0] wr_win_field;
  logic cfg_req;
  logic ctl_rd_take;

  cms_evt_if evt ();
  assign evt.err = evt_err;
  assign evt.wake = evt_wake;
  assign evt.tx = evt_tx;
  assign evt.rx = evt_rx;
  assign evt.prog = evt_prog;
  assign evt.prog_is_rx = evt_prog_is_rx;
  assign evt.fmode = functional_mode_select_ff;

  cms_irq_encoder u_enc (
    .ev(evt)
  );

  // Write channel: address and data taken in either order, then one response
  assign wr_fire = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign ctl_wr = wr_fire && (aw_addr_ff == `CMS_OFF_CONTROL) && w_strb_ff[0];
  assign fmode_wr = wr_fire && (aw_addr_ff == `CMS_OFF_FUNC) && w_strb_ff[0];

  // Field views used by the checks below
  assign wr_req_field = w_data_ff[`CMS_CTL_REQ_LSB +: 3];
  assign wr_win_field = w_data_ff[`CMS_CTL_WIN_LSB +: 3];
  assign cfg_req = mode_request_ff[2];
  assign ctl_rd_take = s_axi_arvalid && s_axi_arready && (s_axi_araddr[3:2] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full_ff && !(s_axi_awvalid && s_axi_awready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_fire) begin
        aw_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_full_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_ff == `CMS_OFF_CONTROL || aw_addr_ff == `CMS_OFF_FUNC ||
                      aw_addr_ff == `CMS_OFF_STATUS || aw_addr_ff == `CMS_OFF_FIFO) ?
                     `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_request_ff <= `CMS_REQ_CONFIG;
      buffer_window_select_ff <= `CMS_WIN_RX0;
    end else if (ctl_wr) begin
      mode_request_ff <= w_data_ff[`CMS_CTL_REQ_LSB +: 3];
      if (functional_mode_select_ff == `CMS_FMODE_LEGACY) begin
        buffer_window_select_ff <= w_data_ff[`CMS_CTL_WIN_LSB +: 3];
      end
    end
  end

  // Functional mode may only change while configuration mode is in force
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      functional_mode_select_ff <= `CMS_FMODE_LEGACY;
    end else if (fmode_wr && mode_status_ff == `CMS_REQ_CONFIG) begin
      functional_mode_select_ff <= w_data_ff[1:0];
    end
  end

  // Abort: software can only set, hardware clears; a new set beats the done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_all_tx_ff <= 1'b0;
    end else if (ctl_wr && w_data_ff[`CMS_CTL_ABORT_BIT]) begin
      abort_all_tx_ff <= 1'b1;
    end else if (tx_abort_done) begin
      abort_all_tx_ff <= 1'b0;
    end
  end

  // Mode in force: configuration waits for idle, others apply at once
  always_comb begin
    nxt_mode_status = mode_status_ff;
    if (mode_request_ff[2]) begin
      if (bus_idle) nxt_mode_status = `CMS_REQ_CONFIG;
    end else begin
      nxt_mode_status = mode_request_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_status_ff <= `CMS_REQ_CONFIG;
    end else begin
      mode_status_ff <= nxt_mode_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_code_ff <= `CMS_IC_NONE;
    end else begin
      irq_code_ff <= evt.code;
    end
  end

  // Read views depend on functional mode
  always_comb begin
    ctl_read = {mode_request_ff, abort_all_tx_ff, 4'h0};
    stat_read = {mode_status_ff, irq_code_ff};
    unique case (functional_mode_select_ff)
      `CMS_FMODE_LEGACY: begin
        ctl_read[3:1] = buffer_window_select_ff;
        stat_read[4] = 1'b0;
        stat_read[0] = 1'b0;
      end
      `CMS_FMODE_FIFO: begin
        ctl_read[3:0] = fifo_read_pointer;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CMS_RESP_OKAY;
        unique case ({s_axi_araddr[3:2], 2'b00})
          `CMS_OFF_CONTROL: s_axi_rdata <= {24'h000000, ctl_read};
          `CMS_OFF_STATUS: s_axi_rdata <= {24'h000000, stat_read};
          `CMS_OFF_FUNC: s_axi_rdata <= {30'h00000000, functional_mode_select_ff};
          `CMS_OFF_FIFO: s_axi_rdata <= {28'h0000000, fifo_read_pointer};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CMS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence cfg_req_busy;
    mode_request_ff[2] && !bus_idle && mode_status_ff != `CMS_REQ_CONFIG;
  endsequence

  AST_CFG_WAITS_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_req_busy |=> mode_status_ff != `CMS_REQ_CONFIG)
    else $error("configuration entered while bus busy");
  AST_CFG_ON_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_request_ff[2] && bus_idle |=> mode_status_ff == `CMS_REQ_CONFIG)
    else $error("configuration not entered on idle");
  AST_OTHER_IMMEDIATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_request_ff[2] |=> mode_status_ff == $past(mode_request_ff))
    else $error("non-configuration mode not applied");
  AST_STATUS_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_status_ff <= `CMS_REQ_CONFIG)
    else $error("reserved mode status");
  AST_ABORT_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_all_tx_ff && tx_abort_done && !ctl_wr |=> !abort_all_tx_ff)
    else $error("abort not cleared");
  AST_ABORT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_wr && w_data_ff[`CMS_CTL_ABORT_BIT] |=> abort_all_tx_ff)
    else $error("abort not set");
  AST_ABORT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(abort_all_tx_ff) |-> $past(ctl_wr))
    else $error("abort set without software");
  AST_LEGACY_CODE_EVEN: assert property (@(posedge aclk) disable iff (!aresetn)
    functional_mode_select_ff == `CMS_FMODE_LEGACY |=> !irq_code_ff[4] && !irq_code_ff[0])
    else $error("legacy code bits 4 or 0 set");
  AST_ERR_PRIORITY: assert property (@(posedge aclk) disable iff (!aresetn)
    evt_err |=> irq_code_ff == `CMS_IC_ERR)
    else $error("bus error not top priority");
  AST_FIFO_VIEW: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_rd_take && functional_mode_select_ff == `CMS_FMODE_FIFO |=>
      s_axi_rdata[3:0] == $past(fifo_read_pointer))
    else $error("fifo pointer not shown");
  AST_ENH_CTL_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_rd_take && functional_mode_select_ff == `CMS_FMODE_ENH |=> s_axi_rdata[3:0] == 4'h0)
    else $error("enhanced low control bits not zero");
  AST_LEGACY_BIT0: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_rd_take && functional_mode_select_ff == `CMS_FMODE_LEGACY |=> !s_axi_rdata[0])
    else $error("legacy control bit 0 not zero");

  // Control writes land one cycle after both channels are taken
  AST_REQ_TAKES_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_wr |=> mode_request_ff == $past(wr_req_field))
    else $error("mode request not written");
  AST_WIN_LEGACY_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_wr && functional_mode_select_ff == `CMS_FMODE_LEGACY |=>
      buffer_window_select_ff == $past(wr_win_field))
    else $error("window not written");
  AST_WIN_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    functional_mode_select_ff != `CMS_FMODE_LEGACY |=> $stable(buffer_window_select_ff))
    else $error("window changed outside legacy mode");
  AST_FMODE_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_status_ff != `CMS_REQ_CONFIG |=> $stable(functional_mode_select_ff))
    else $error("functional mode changed outside configuration");

  // A status move while configuration is requested must be the idle entry
  sequence status_moves_on_cfg;
    $changed(mode_status_ff) && $past(cfg_req);
  endsequence

  AST_STATUS_ON_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    status_moves_on_cfg |-> $past(bus_idle) && mode_status_ff == `CMS_REQ_CONFIG)
    else $error("status moved without completed configuration entry");
  AST_RESET_VALUES: assert property (@(posedge aclk) !aresetn |=>
    mode_status_ff == `CMS_REQ_CONFIG && mode_request_ff == `CMS_REQ_CONFIG &&
    !abort_all_tx_ff && irq_code_ff == `CMS_IC_NONE)
    else $error("reset values not applied");

  // Interrupt code checks; the code register lags the events by one cycle
  sequence legacy_wake_only;
    functional_mode_select_ff == `CMS_FMODE_LEGACY && evt_wake && !evt_err &&
      evt_tx == 3'h0 && evt_rx == 2'h0;
  endsequence

  sequence legacy_rx1_top;
    functional_mode_select_ff == `CMS_FMODE_LEGACY && evt_rx[1] && !evt_err &&
      evt_tx == 3'h0;
  endsequence

  // Receiving programmable buffers only, no dedicated source pending
  sequence prog_rx_only;
    functional_mode_select_ff != `CMS_FMODE_LEGACY && evt_prog != 6'h00 &&
      (evt_prog & ~evt_prog_is_rx) == 6'h00 && !evt_err && !evt_wake &&
      evt_tx == 3'h0 && evt_rx == 2'h0;
  endsequence

  AST_WAKE_LEGACY: assert property (@(posedge aclk) disable iff (!aresetn)
    legacy_wake_only |=> irq_code_ff[3:1] == 3'h7)
    else $error("legacy wake-up code not 111");
  AST_RX1_CODE_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
    legacy_rx1_top |=> irq_code_ff[3:1] == `CMS_WIN_RX1)
    else $error("receive buffer 1 code does not select its window");
  AST_PROG_RX_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_rx_only |=> irq_code_ff == 5'h10)
    else $error("receiving programmable buffer code wrong");
  AST_ENH_CODE_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    functional_mode_select_ff != `CMS_FMODE_LEGACY |=> irq_code_ff < 5'h18)
    else $error("reserved enhanced code");
endmodule

// File: sim/cms_engine_model.sv
// Behavioural protocol engine facing the mode/status control block.
// Assumes the bench sets bus activity, abort lag and the FIFO pointer.
`timescale 1ns/1ps
module cms_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench commands
  input wire logic bus_busy,
  input wire logic [3:0] abort_lag,
  input wire logic [3:0] fp_value,
  // From the block
  input wire logic abort_all_tx_ff,
  // To the block
  output logic bus_idle,
  output logic tx_abort_done,
  output logic [3:0] fifo_read_pointer
);
  logic [3:0] lag_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_idle <= 1'b1;
      fifo_read_pointer <= 4'h0;
    end else begin
      bus_idle <= !bus_busy;
      fifo_read_pointer <= fp_value;
    end
  end
  // Done is a one-cycle pulse, so a lingering abort is not cleared twice
  always_ff @(posedge aclk) begin
    if (!aresetn || !abort_all_tx_ff || tx_abort_done) begin
      lag_ff <= 4'h0;
      tx_abort_done <= 1'b0;
    end else if (lag_ff >= abort_lag) begin
      tx_abort_done <= 1'b1;
    end else begin
      lag_ff <= lag_ff + 4'h1;
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the mode/status block through AXI4-Lite.
// Assumes cms_ctrl and the engine model; interrupt events driven here.
`timescale 1ns/1ps
`include "cms_defines.svh"
module tb_top;
  localparam logic [3:0] CT = `CMS_OFF_CONTROL;
  localparam logic [3:0] ST = `CMS_OFF_STATUS;
  localparam logic [3:0] FN = `CMS_OFF_FUNC;
  localparam logic [4:0] M0 [0:6] = '{`CMS_IC_ERR, `CMS_IC_WAKE_M0, `CMS_IC_TX0, `CMS_IC_TX1,
    `CMS_IC_TX2, `CMS_IC_RX0_M0, `CMS_IC_RX1_M0};
  localparam logic [4:0] M1 [0:6] = '{`CMS_IC_ERR, `CMS_IC_WAKE_EN, `CMS_IC_TX0, `CMS_IC_TX1,
    `CMS_IC_TX2, `CMS_IC_RX0_EN, `CMS_IC_RX1_EN};
  localparam logic [2:0] W0 [0:6] = '{3'h0, 3'h0, `CMS_WIN_TX0, `CMS_WIN_TX1, `CMS_WIN_TX2,
    3'h6, `CMS_WIN_RX1};
  localparam logic [2:0] RQ [0:4] = '{`CMS_REQ_NORMAL, `CMS_REQ_SLEEP, `CMS_REQ_LOOP,
    `CMS_REQ_LISTEN, `CMS_REQ_NORMAL};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, functional_mode_select_ff, br, rr;
  logic [2:0] mode_status_ff, buffer_window_select_ff;
  logic abort_all_tx_ff, bus_idle, tx_abort_done;
  logic bus_busy = 1'b0;
  logic [3:0] fifo_read_pointer, abort_lag = 4'h0, fp_value = 4'h0;
  logic [18:0] evs = 19'h0;
  int miscompares = 0;
  int n_compared = 0;
  cms_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus_idle, .tx_abort_done, .fifo_read_pointer,
    .evt_err(evs[0]), .evt_wake(evs[1]), .evt_tx(evs[4:2]), .evt_rx(evs[6:5]),
    .evt_prog(evs[12:7]), .evt_prog_is_rx(evs[18:13]), .mode_status_ff, .abort_all_tx_ff,
    .buffer_window_select_ff, .functional_mode_select_ff);
  cms_engine_model i_eng (.aclk, .aresetn, .bus_busy, .abort_lag, .fp_value,
    .abort_all_tx_ff, .bus_idle, .tx_abort_done, .fifo_read_pointer);
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdt(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    rdt(a, rd);
    chk(rd, exp);
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rc(CT, 32'h80);
    chk(rr, `CMS_RESP_OKAY);
    rc(ST, 32'h80);
    wr(ST, 32'hFF);
    chk(br, `CMS_RESP_OKAY);
    rc(ST, 32'h80);
    // Legacy codes, then copy each buffer code into the window
    for (int i = 0; i < 7; i++) begin
      evs <= 19'h1 << i;
      repeat (3) @(posedge aclk);
      rc(ST, {24'h0, `CMS_REQ_CONFIG, M0[i]});
      wr(CT, {24'h0, `CMS_REQ_CONFIG, 1'b0, rd[3:1], 1'b0});
      if (i > 1) chk(buffer_window_select_ff, W0[i]);
    end
    evs <= 19'h15;
    repeat (3) @(posedge aclk);
    rc(ST, {24'h0, `CMS_REQ_CONFIG, `CMS_IC_ERR});
    wr(CT, 32'h8B);
    rc(CT, 32'h8A);
    wr(FN, 32'h1);
    rc(FN, 32'h1);
    for (int i = 0; i < 13; i++) begin
      evs <= 19'h1 << i;
      repeat (3) @(posedge aclk);
      rc(ST, {24'h0, `CMS_REQ_CONFIG, (i < 7) ? M1[i] : `CMS_IC_PROG0_EN + 5'(i - 7)});
    end
    evs <= 19'h08200;
    repeat (3) @(posedge aclk);
    rc(ST, {24'h0, `CMS_REQ_CONFIG, `CMS_IC_RX0_EN});
    evs <= 19'h0;
    wr(CT, 32'h8F);
    rc(CT, 32'h80);
    wr(FN, 32'h2);
    for (int p = 0; p < 8; p++) begin
      fp_value <= 4'(p);
      repeat (3) @(posedge aclk);
      rc(CT, 32'h80 | p);
    end
    wr(FN, 32'h0);
    rc(FN, 32'h0);
    // Sleep request also stands for parking the unit before a device sleep
    for (int i = 0; i < 5; i++) begin
      wr(CT, {24'h0, RQ[i], 5'h0});
      rc(ST, {24'h0, RQ[i], 5'h0});
    end
    wr(FN, 32'h1);
    rc(FN, 32'h0);
    chk(functional_mode_select_ff, 32'h0);
    bus_busy <= 1'b1;
    wr(CT, 32'hE0);
    repeat (5) @(posedge aclk);
    rc(ST, 32'h00);
    chk(mode_status_ff, `CMS_REQ_NORMAL);
    bus_busy <= 1'b0;
    for (int n = 0; n < 20 && rd[7:5] !== `CMS_REQ_CONFIG; n++) rdt(ST, rd);
    chk(rd, 32'h80);
    abort_lag <= 4'hA;
    wr(CT, 32'h90);
    chk(abort_all_tx_ff, 32'h1);
    rc(CT, 32'h90);
    repeat (15) @(posedge aclk);
    rc(CT, 32'h80);
    abort_lag <= 4'h0;
    wr(CT, 32'h90);
    repeat (4) @(posedge aclk);
    chk(abort_all_tx_ff, 32'h0);
    // A write without byte lane 0 must leave the control fields alone
    s_axi_wstrb <= 4'h0;
    wr(CT, 32'h00);
    rc(CT, 32'h80);
    s_axi_wstrb <= 4'hF;
    finish_test;
  end
endmodule
